// ==== core/watchdog_timer_block.sv ====
// Function
// R1 - Mode 11 keeps the watchdog running always, in Sleep too, whatever the software enable says.
// R2 - Mode 10 runs the watchdog while awake and stops it in Sleep, ignoring the software enable.
// R3 - Mode 01 runs the watchdog exactly when the software enable is 1, in Sleep or not.
// R4 - Mode 00 keeps the watchdog stopped in every state and ignores the software enable.
// R5 - After any reset the period select field holds 01011, a ratio of 65536 and about two seconds.
// R6 - Period code 00000 means 32 oscillator cycles and each step doubles it up to code 10010.
// R7 - Codes 10011 to 11111 behave as the shortest interval of 32 cycles.
// R8 - The count clears on reset, clear instruction, Sleep entry, wake by interrupt, oscillator fail, disable and start-up timer.
// R9 - Clock switches and divider changes leave the count and enable untouched.
// R10 - Entering Sleep clears the count, which then counts on from zero if the mode runs in Sleep.
// R11 - Leaving Sleep clears the count again and holds it at zero while the start-up timer runs.
// R12 - A time-out in Sleep wakes the device instead of resetting it and updates the time-out and power-down flags.
// R13 - Control bits 7:6 read zero, bits 5:1 are the period select and bit 0 the software enable, reset to 0.
// R14 - The count advances on cycles of the 31 kHz low-frequency oscillator.
// R15 - While awake and running, a missing clear before time-out requests a device reset.
// R16 - The watchdog time base does not depend on the system clock selection; here the tick is pclk divided by WDT_LF_DIV.
// R17 - Time-out is a one-cycle event sent to reset logic when awake and to wake logic when asleep.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"

module watchdog_timer_block (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration
    input wire logic [1:0] wdt_mode_config,
    // Core events
    input wire logic clear_watchdog_instruction,
    input wire logic sleep_enter,
    input wire logic wake_interrupt,
    input wire logic osc_fail,
    input wire logic osc_startup_timer,
    // Results
    output logic wdt_reset_req,
    output logic wdt_wake_req,
    output logic timeout_status_n,
    output logic powerdown_status_n,
    output logic irq
);

    wdt_cnt_if cif ();

    logic [7:0] watchdog_control_reg_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    logic [9:0] lf_div_r;
    logic lf_tick_r;
    logic to_n_r;
    logic pd_n_r;
    logic reset_req_r;
    logic wake_req_r;
    logic run;
    logic asleep;
    logic wr_en;
    logic rd_sel_ok;
    logic [31:0] rdata_nxt;
    logic [1:0] irq_set;
    logic sleep_evt;
    logic wake_evt;
    logic count_clear;
    logic sel_ctrl;
    logic sel_stat;
    logic sel_mask;
    logic sel_status;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    logic rd_setup;
    logic [1:0] wr_bits;
    logic [3:0] status_bits;
    wdt_pkg::wdt_mode_t mode;
    wdt_pkg::pwr_state_t state_r;
    wdt_pkg::pwr_state_t state_nxt;

    // Mode field and current power state
    assign mode = wdt_pkg::wdt_mode_t'(wdt_mode_config);
    assign asleep = (state_r == wdt_pkg::ST_SLEEP);

    // Sleep entry acts only while awake, a wake interrupt only while asleep
    assign sleep_evt = sleep_enter && !asleep; // R10
    assign wake_evt = asleep && wake_interrupt; // R8

    // Enable decode per operating mode
    always_comb begin
        case (mode)
            wdt_pkg::MODE_ON: run = 1'b1; // R1
            wdt_pkg::MODE_NO_SLEEP: run = !asleep; // R2
            wdt_pkg::MODE_SW: run = watchdog_control_reg_r[`WDT_EN_BIT]; // R3
            default: run = 1'b0; // R4
        endcase
    end

    // Low-frequency oscillator tick, made by dividing pclk by WDT_LF_DIV,
    // so any change of the pclk rate stretches or shortens it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lf_div_r <= 10'h000;
            lf_tick_r <= 1'b0;
        end else if (lf_div_r == 10'(`WDT_LF_DIV - 1)) begin
            lf_div_r <= 10'h000; // R14 R16
            lf_tick_r <= 1'b1;
        end else begin
            lf_div_r <= lf_div_r + 10'h001;
            lf_tick_r <= 1'b0;
        end
    end

    // Clearing sources; any one of them holds the count at zero for that cycle
    always_comb begin
        count_clear = 1'b0;
        if (clear_watchdog_instruction || osc_fail) begin
            count_clear = 1'b1; // R8
        end
        if (sleep_evt) begin
            count_clear = 1'b1; // R10
        end
        if (wake_evt) begin
            count_clear = 1'b1; // R8
        end
        if (osc_startup_timer || state_r == wdt_pkg::ST_OST) begin
            count_clear = 1'b1; // R11
        end
    end

    // Counter hookup; clock switching is not an input, so nothing else clears it
    assign cif.lf_tick = lf_tick_r;
    assign cif.run = run; // R9
    assign cif.period = watchdog_control_reg_r[`WDT_PS_MSB:`WDT_PS_LSB];
    assign cif.clear = count_clear;

    wdt_counter u_counter (
        .pclk(pclk),
        .presetn(presetn),
        .c(cif.cnt)
    );

    // Power state tracking
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            wdt_pkg::ST_AWAKE: begin
                if (sleep_enter) begin
                    state_nxt = wdt_pkg::ST_SLEEP; // R10
                end
            end
            wdt_pkg::ST_SLEEP: begin
                if (wake_interrupt || cif.expire) begin
                    state_nxt = wdt_pkg::ST_OST; // R11 R12
                end
            end
            wdt_pkg::ST_OST: begin
                if (!osc_startup_timer) begin
                    state_nxt = wdt_pkg::ST_AWAKE; // R11
                end
            end
            default: state_nxt = wdt_pkg::ST_AWAKE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= wdt_pkg::ST_AWAKE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Time-out routing: reset when awake, wake when asleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_req_r <= 1'b0;
            wake_req_r <= 1'b0;
        end else begin
            reset_req_r <= cif.expire && !asleep; // R15 R17
            wake_req_r <= cif.expire && asleep; // R12 R17
        end
    end

    // Time-out and power-down flags, time-out wins over a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            to_n_r <= 1'b1;
            pd_n_r <= 1'b1;
        end else if (cif.expire) begin
            to_n_r <= 1'b0; // R12
            pd_n_r <= !asleep;
        end else if (clear_watchdog_instruction) begin
            to_n_r <= 1'b1;
            pd_n_r <= 1'b1;
        end else if (sleep_evt) begin
            to_n_r <= 1'b1;
            pd_n_r <= 1'b0;
        end
    end

    // Register select, one-hot: control, event status, event mask, state status
    function automatic logic [3:0] reg_select(input logic [7:0] addr);
        logic [3:0] sel;
        sel = 4'h0;
        if (addr == `WDT_CTRL_OFS) begin
            sel = 4'h1;
        end else if (addr == `WDT_IRQ_STAT_OFS) begin
            sel = 4'h2;
        end else if (addr == `WDT_IRQ_MASK_OFS) begin
            sel = 4'h4;
        end else if (addr == `WDT_STATUS_OFS) begin
            sel = 4'h8;
        end
        reg_select = sel;
    endfunction

    // APB decode: zero wait states, so every access phase ends at its first edge
    assign {sel_status, sel_mask, sel_stat, sel_ctrl} = reg_select(paddr);
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign rd_sel_ok = sel_ctrl || sel_stat || sel_mask || sel_status;
    assign pslverr = psel && penable && !rd_sel_ok;

    // Per-register write strobes and the event bits a write carries
    assign wr_ctrl = wr_en && sel_ctrl;
    assign wr_stat = wr_en && sel_stat;
    assign wr_mask = wr_en && sel_mask;
    assign wr_bits = pwdata[1:0];

    // Control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_control_reg_r <= `WDT_CTRL_RST; // R5 R13
        end else if (wr_ctrl) begin
            watchdog_control_reg_r <= {2'b00, pwdata[5:0]}; // R13
        end
    end

    // Interrupt mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= 2'b00;
        end else if (wr_mask) begin
            irq_mask_r <= wr_bits;
        end
    end

    // Sticky event bits, write one to clear, set wins
    assign irq_set = {wake_req_r, reset_req_r};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= 2'b00;
        end else if (wr_stat) begin
            irq_stat_r <= (irq_stat_r & ~wr_bits) | irq_set;
        end else begin
            irq_stat_r <= irq_stat_r | irq_set;
        end
    end

    // Live state word shown by the status register
    assign status_bits = {asleep, run, pd_n_r, to_n_r};

    // Read data mux
    always_comb begin
        rdata_nxt = 32'h00000000;
        if (sel_ctrl) begin
            rdata_nxt = {24'h000000, watchdog_control_reg_r}; // R13
        end else if (sel_stat) begin
            rdata_nxt = {30'h00000000, irq_stat_r};
        end else if (sel_mask) begin
            rdata_nxt = {30'h00000000, irq_mask_r};
        end else if (sel_status) begin
            rdata_nxt = {28'h0000000, status_bits};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= rdata_nxt;
        end
    end

    // Outputs
    assign wdt_reset_req = reset_req_r;
    assign wdt_wake_req = wake_req_r;
    assign timeout_status_n = to_n_r;
    assign powerdown_status_n = pd_n_r;

    // Level interrupt: any unmasked sticky event
    assign irq = |(irq_stat_r & irq_mask_r);

endmodule // watchdog_timer_block

`default_nettype wire

// ==== core/wdt_cnt_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface wdt_cnt_if;
    logic lf_tick;
    logic clear;
    logic run;
    logic [4:0] period;
    logic expire;
    logic [22:0] count;

    modport ctrl (output lf_tick, output clear, output run, output period, input expire, input count);
    modport cnt (input lf_tick, input clear, input run, input period, output expire, output count);
endinterface

`default_nettype wire

// ==== core/wdt_counter.sv ====
`timescale 1ns/1ps
`default_nettype none

module wdt_counter (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control side
    wdt_cnt_if.cnt c
);

    logic [22:0] count_r;
    logic expire_r;
    logic hit;

    // Terminal count for the selected ratio
    assign hit = c.lf_tick && (count_r == wdt_pkg::ratio_last(c.period)); // R6 R7 R17

    // Oscillator-cycle counter, held at zero while cleared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= 23'h000000; // R8
        end else if (c.clear || !c.run) begin
            count_r <= 23'h000000; // R8
        end else if (hit) begin
            count_r <= 23'h000000;
        end else if (c.lf_tick) begin
            count_r <= count_r + 23'h000001; // R14
        end
    end

    // One-cycle time-out event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            expire_r <= 1'b0;
        end else begin
            expire_r <= hit && c.run && !c.clear; // R17
        end
    end

    // Results back to the control side
    assign c.expire = expire_r;
    assign c.count = count_r;

endmodule // wdt_counter

`default_nettype wire

// ==== core/wdt_defs.svh ====
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// Register byte offsets
`define WDT_CTRL_OFS 8'h00
`define WDT_IRQ_STAT_OFS 8'h04
`define WDT_IRQ_MASK_OFS 8'h08
`define WDT_STATUS_OFS 8'h0c

// Control register fields and reset value
`define WDT_EN_BIT 0
`define WDT_PS_LSB 1
`define WDT_PS_MSB 5
`define WDT_CTRL_RST 8'h16
`define WDT_PS_RST 5'h0b
`define WDT_PS_MAX 5'h12

// Interrupt status bit positions
`define WDT_IRQ_RESET_BIT 0
`define WDT_IRQ_WAKE_BIT 1

// Status register bit positions
`define WDT_ST_TO_BIT 0
`define WDT_ST_PD_BIT 1
`define WDT_ST_RUN_BIT 2
`define WDT_ST_SLEEP_BIT 3

// Time base: system clock and low-frequency oscillator rates in Hz
`define WDT_CLK_HZ 20000000
`define WDT_LF_HZ 31000
`define WDT_LF_DIV (`WDT_CLK_HZ / `WDT_LF_HZ)
`define WDT_MIN_RATIO 23'h000020

`endif

// ==== core/wdt_pkg.sv ====
`include "wdt_defs.svh"

package wdt_pkg;

    // Operating modes of the two-bit configuration field
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_SW = 2'h1,
        MODE_NO_SLEEP = 2'h2,
        MODE_ON = 2'h3
    } wdt_mode_t;

    // Device power states, one-hot
    typedef enum logic [2:0] {
        ST_AWAKE = 3'b001,
        ST_SLEEP = 3'b010,
        ST_OST = 3'b100
    } pwr_state_t;

    // Last count value before time-out for a period select code
    function automatic logic [22:0] ratio_last(input logic [4:0] ps);
        logic [4:0] sh;
        sh = (ps <= `WDT_PS_MAX) ? ps : 5'h00;
        ratio_last = (`WDT_MIN_RATIO << sh) - 23'h000001;
    endfunction

endpackage

// ==== tb/core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module core_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Wake report from the watchdog
    input wire logic wdt_wake_req,
    // Core events
    output logic clear_watchdog_instruction,
    output logic sleep_enter,
    output logic wake_interrupt,
    output logic osc_startup_timer
);
    logic [3:0] ost_r;
    // Start-up timer runs eight cycles after each wake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ost_r <= 4'h0;
        end else if (wdt_wake_req || wake_interrupt) begin
            ost_r <= 4'h8;
        end else if (ost_r != 4'h0) begin
            ost_r <= ost_r - 4'h1;
        end
    end
    assign osc_startup_timer = ost_r != 4'h0;
    initial {wake_interrupt, sleep_enter, clear_watchdog_instruction} = 3'h0;
    // One-cycle pulse: bit 0 clear, bit 1 sleep, bit 2 wake
    task automatic ev(input logic [2:0] m);
        {wake_interrupt, sleep_enter, clear_watchdog_instruction} <= m;
        @(posedge pclk);
        {wake_interrupt, sleep_enter, clear_watchdog_instruction} <= 3'h0;
        @(posedge pclk);
    endtask
endmodule // core_model
`default_nettype wire

// ==== tb/watchdog_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module watchdog_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] paddr,
    // Mode and core events
    input wire logic [1:0] wdt_mode_config,
    input wire logic clear_watchdog_instruction,
    input wire logic sleep_enter,
    input wire logic osc_fail,
    input wire logic osc_startup_timer,
    // Results
    input wire logic wdt_reset_req,
    input wire logic wdt_wake_req,
    input wire logic timeout_status_n,
    input wire logic powerdown_status_n
);
    // Short names for the two time-out events
    wire logic rq = wdt_reset_req;
    wire logic wk = wdt_wake_req;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_RQ_PULSE: assert property (rq |=> !rq) else $error("long reset request");
    AST_WK_PULSE: assert property (wk |=> !wk) else $error("long wake request");
    AST_ONE_PATH: assert property (!(rq && wk)) else $error("reset and wake together");
    AST_MODE_OFF: assert property (wdt_mode_config == 2'h0 && $past(wdt_mode_config, 2) == 2'h0 |-> !rq && !wk)
        else $error("time-out while off");
    AST_TO_FLAG: assert property (rq |-> !timeout_status_n) else $error("flag missing");
    AST_WAKE_PD: assert property (wk |-> !powerdown_status_n) else $error("wake while awake");
    AST_SLEEP_PD: assert property (sleep_enter && !clear_watchdog_instruction |=> !powerdown_status_n)
        else $error("sleep not flagged");
    AST_CLR_PD: assert property (clear_watchdog_instruction && !sleep_enter |=> powerdown_status_n)
        else $error("clear left flag");
    AST_OSC_FAIL: assert property (osc_fail [*3] |-> !rq && !wk) else $error("time-out in fail");
    AST_OST_HOLD: assert property (osc_startup_timer [*3] |-> !rq && !wk) else $error("time-out in start-up");
    AST_APB_ERR: assert property (psel && penable && paddr > 8'h0c |-> pslverr && pready)
        else $error("unmapped access");
endmodule // watchdog_asserts

bind watchdog_timer_block watchdog_asserts u_chk (.*);
`default_nettype wire

// ==== tb/watchdog_timer_block_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_block_tb;
    localparam int LO = 31 * 645; // 645 system cycles per oscillator cycle
    localparam int HI = 32 * 645 + 4;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, osc_fail = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0] wdt_mode_config = 2'h0;
    logic pready, pslverr, se, clear_watchdog_instruction, sleep_enter, wake_interrupt, osc_startup_timer;
    logic wdt_reset_req, wdt_wake_req, timeout_status_n, powerdown_status_n, irq;
    int err_count = 0, n_checks = 0, cyc = 0, n;

    watchdog_timer_block u_dut (.*);
    core_model u_core (.*);

    // Clock
    always #25 pclk = ~pclk;

    // Cycle ceiling cuts a hang short
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 80000) begin
            err_count++;
            test_done();
        end
    end

    task automatic test_done;
        if (err_count == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer, read data and error taken at the pready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Wait for a time-out event, n counts the cycles
    task automatic wait_req;
        n = 0;
        while (wdt_reset_req !== 1'b1 && wdt_wake_req !== 1'b1 && n < 22000) begin
            @(posedge pclk);
            n++;
        end
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 8'h00, 0);
        check(rd, 32'h16, "ctrl reset");
        apb(0, 8'h0c, 0);
        check(rd, 32'h3, "status reset");
        apb(0, 8'h10, 0);
        check({rd[30:0], se}, 32'h1, "unmapped");
        apb(1, 8'h00, 32'hff);
        apb(0, 8'h00, 0);
        check(rd, 32'h3f, "ctrl bits");
        // Software mode, enabled, reserved period code
        wdt_mode_config <= 2'h1;
        wait_req;
        check(n > LO && n < HI && wdt_reset_req, 1, "awake time-out");
        check(timeout_status_n, 0, "timeout flag");
        @(posedge pclk);
        apb(0, 8'h04, 0);
        check(rd, 32'h1, "reset event");
        check(irq, 0, "irq masked");
        apb(1, 8'h08, 32'h3);
        check(irq, 1, "irq unmasked");
        apb(1, 8'h04, 32'h1);
        check(irq, 0, "irq cleared");
        u_core.ev(3'h1);
        check(timeout_status_n, 1, "flag after clear");
        // Software mode with the enable off stops the watchdog
        apb(1, 8'h00, 32'h0);
        apb(0, 8'h0c, 0);
        check(rd, 32'h3, "sw mode off");
        // Always-on mode with enable off: time-out in Sleep wakes
        wdt_mode_config <= 2'h3;
        u_core.ev(3'h2);
        wait_req;
        check(n > LO && n < HI && wdt_wake_req, 1, "sleep time-out");
        check({timeout_status_n, powerdown_status_n}, 0, "sleep flags");
        @(posedge pclk);
        apb(0, 8'h04, 0);
        check(rd, 32'h2, "wake event");
        repeat (12) @(posedge pclk);
        // Off-in-Sleep mode: oscillator fail, then no time-out in Sleep
        wdt_mode_config <= 2'h2;
        osc_fail <= 1'b1;
        repeat (4) @(posedge pclk);
        osc_fail <= 1'b0;
        apb(0, 8'h0c, 0);
        check(rd[2], 1, "mode 10 awake");
        u_core.ev(3'h2);
        wait_req;
        check(n, 22000, "mode 10 sleep");
        apb(0, 8'h0c, 0);
        check(rd[3:2], 2'h2, "mode 10 asleep");
        u_core.ev(3'h4);
        repeat (12) @(posedge pclk);
        test_done();
    end
endmodule // watchdog_timer_block_tb
`default_nettype wire
